// file: cfg_host.sv
// smbus host model driving the byte register port
`timescale 1ns/1ns
module cfg_host (
	// clock and read answer
	input  wire logic       clk,
	input  wire logic       rvalid,
	input  wire logic [7:0] rdata,
	// register port strobes
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            write,
	output logic            read
);
	initial {addr, wdata, write, read} = '0;
	// one byte write; data inverted once released
	task automatic wr(input logic [7:0] a, dv);
		@(posedge clk) {addr, wdata, write} <= {a, dv, 1'b1};
		@(posedge clk) {write, wdata} <= {1'b0, ~dv};
	endtask
	// one byte read, answer taken the edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] dv, output logic v);
		@(posedge clk) {addr, read} <= {a, 1'b1};
		@(posedge clk) read <= 1'b0;
		#1 {v, dv} = {rvalid, rdata};
	endtask
endmodule

// file: desc_string_pkg.sv
// constants for the descriptor string configuration register bank
package desc_string_pkg;
	// register byte offsets
	localparam logic [7:0] UNIQUE_ID_BASE          = 8'h10;
	localparam logic [7:0] UNIQUE_ID_LAST          = 8'h1F;
	localparam logic [7:0] LANGUAGE_CODE_LOW_ADDR  = 8'h20;
	localparam logic [7:0] LANGUAGE_CODE_HIGH_ADDR = 8'h21;
	localparam logic [7:0] SERIAL_LENGTH_ADDR      = 8'h22;
	localparam logic [7:0] MAKER_LENGTH_ADDR       = 8'h23;

	// values after reset
	localparam logic [7:0] LANGUAGE_CODE_LOW_RESET  = 8'h09;
	localparam logic [7:0] LANGUAGE_CODE_HIGH_RESET = 8'h04;
	localparam logic [5:0] SERIAL_LENGTH_RESET      = 6'h18;
	localparam logic [6:0] MAKER_LENGTH_RESET       = 7'h00;

	// field widths and largest permitted lengths
	localparam int         SERIAL_LENGTH_WIDTH = 6;
	localparam int         MAKER_LENGTH_WIDTH  = 7;
	localparam logic [5:0] SERIAL_LENGTH_MAX   = 6'h20;
	localparam logic [6:0] MAKER_LENGTH_MAX    = 7'h40;

	// string descriptor indices served here and the language code payload size
	localparam logic [1:0] STRING_INDEX_LANGUAGE = 2'h0;
	localparam logic [1:0] STRING_INDEX_SERIAL   = 2'h1;
	localparam logic [1:0] STRING_INDEX_MAKER    = 2'h3;
	localparam logic [7:0] LANGUAGE_CODE_BYTES   = 8'h02;

	// identifier format fields: version nibble (byte 6) and variant bits (byte 8)
	localparam int         UID_VERSION_BYTE = 6;
	localparam logic [3:0] UID_VERSION      = 4'h4;
	localparam int         UID_VARIANT_BYTE = 8;
	localparam logic [1:0] UID_VARIANT      = 2'h2;
endpackage

// file: descriptor_string_config_regs.sv
// descriptor string configuration registers: identifier, language code, string lengths
//
// Functional notes
// - Sixteen read-only identifier bytes at 10h-1Fh feed the container identifier descriptor.
// - The identifier follows the UUID URN namespace format: version and variant fields.
// - Language code low byte at 20h resets to 09h, returned as low byte.
// - Language code high byte at 21h resets to 04h, returned as high byte.
// - Exactly one language code is reported at string index 0, default 0409h.
// - String override enable high lets writers change language bytes and maker length.
// - Serial length field bits 5:0, reset 18h, never above 32 bytes.
// - Serial override enable high lets writers change the serial length field.
// - Nonzero serial length returns that many serial bytes at string index 1.
// - Maker length field bits 6:0, reset 0, never above 64 bytes.
// - Nonzero maker length returns that many maker bytes at string index 3.
// - Serial length bits 7:6 and maker length bit 7 read as zero.
`timescale 1ns/1ns
module descriptor_string_config_regs
	import desc_string_pkg::*;
#(
	parameter logic [127:0] UID_SEED = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // arbitrary
) (
	// clock, reset, enable
	input  wire logic                           CLK_SYS,
	input  wire logic                           RESET,
	input  wire logic                           CE,
	// override enables from the configuration registers
	input  wire logic                           STRING_OVERRIDE_ENABLE,
	input  wire logic                           SERIAL_OVERRIDE_ENABLE,
	// byte register port (smbus host or eeprom loader)
	input  wire logic [7:0]                     REG_ADDR,
	input  wire logic [7:0]                     REG_WDATA,
	input  wire logic                           REG_WRITE,
	input  wire logic                           REG_READ,
	output logic      [7:0]                     REG_RDATA,
	output logic                                REG_RVALID,
	// descriptor logic request
	input  wire logic                           DESC_REQ,
	input  wire logic [1:0]                     DESC_INDEX,
	output logic                                DESC_ACK,
	output logic      [7:0]                     DESC_LENGTH,
	output logic                                DESC_PRESENT,
	// descriptor field values
	output logic      [127:0]                   UNIQUE_ID,
	output logic      [15:0]                    LANGUAGE_CODE,
	output logic      [SERIAL_LENGTH_WIDTH-1:0] SERIAL_STRING_LENGTH,
	output logic      [MAKER_LENGTH_WIDTH-1:0]  MAKER_STRING_LENGTH
);

	// force the version and variant fields onto the identifier
	function automatic logic [127:0] format_uid(input logic [127:0] seed);
		logic [127:0] uid;
		uid = seed;
		uid[UID_VERSION_BYTE*8+4 +: 4] = UID_VERSION;
		uid[UID_VARIANT_BYTE*8+6 +: 2] = UID_VARIANT;
		return uid;
	endfunction

	// clamp a written length to its largest permitted value
	function automatic logic [7:0] clamp_length(input logic [7:0] value, input logic [7:0] limit);
		return (value > limit) ? limit : value;
	endfunction

	// identifier is fixed at build time and needs no storage
	localparam logic [127:0] UID_VALUE = format_uid(UID_SEED);

	// stored fields and their next values
	logic [7:0]                     language_code_low;
	logic [7:0]                     language_code_high;
	logic [SERIAL_LENGTH_WIDTH-1:0] serial_string_length;
	logic [MAKER_LENGTH_WIDTH-1:0]  maker_string_length;
	logic [7:0]                     next_language_code_low;
	logic [7:0]                     next_language_code_high;
	logic [SERIAL_LENGTH_WIDTH-1:0] next_serial_string_length;
	logic [MAKER_LENGTH_WIDTH-1:0]  next_maker_string_length;
	logic [7:0]                     serial_clamped;
	logic [7:0]                     maker_clamped;

	// writable fields: stored only while their override enable is high
	always_comb begin
		next_language_code_low  = language_code_low;
		next_language_code_high = language_code_high;
		next_serial_string_length = serial_string_length;
		next_maker_string_length  = maker_string_length;
		// field values over the limit clamp to the maximum; written bits above the field are dropped
		serial_clamped = clamp_length({2'h0, REG_WDATA[5:0]}, {2'h0, SERIAL_LENGTH_MAX});
		maker_clamped  = clamp_length({1'h0, REG_WDATA[6:0]}, {1'h0, MAKER_LENGTH_MAX});
		// unmapped or read-only addresses fall to the default and change nothing
		if (REG_WRITE) begin
			case (REG_ADDR)
				LANGUAGE_CODE_LOW_ADDR: begin
					if (STRING_OVERRIDE_ENABLE) next_language_code_low = REG_WDATA;
				end
				LANGUAGE_CODE_HIGH_ADDR: begin
					if (STRING_OVERRIDE_ENABLE) next_language_code_high = REG_WDATA;
				end
				SERIAL_LENGTH_ADDR: begin
					if (SERIAL_OVERRIDE_ENABLE) begin
						next_serial_string_length = serial_clamped[5:0];
					end
				end
				MAKER_LENGTH_ADDR: begin
					if (STRING_OVERRIDE_ENABLE) begin
						next_maker_string_length = maker_clamped[6:0];
					end
				end
				default: begin
					next_language_code_low = language_code_low;
				end
			endcase
		end
	end

	// field registers; reset also waits for the enable, so a frozen bank keeps all
	always_ff @(posedge CLK_SYS) begin
		if (CE) begin
			if (RESET) begin
				language_code_low    <= LANGUAGE_CODE_LOW_RESET;
				language_code_high   <= LANGUAGE_CODE_HIGH_RESET;
				serial_string_length <= SERIAL_LENGTH_RESET;
				maker_string_length  <= MAKER_LENGTH_RESET;
			end else begin
				language_code_low    <= next_language_code_low;
				language_code_high   <= next_language_code_high;
				serial_string_length <= next_serial_string_length;
				maker_string_length  <= next_maker_string_length;
			end
		end
	end

	// read data path, one cycle after the read strobe
	logic [7:0] next_rdata;
	logic       next_rvalid;
	logic [3:0] uid_byte_sel;

	always_comb begin
		next_rdata   = 8'h00;
		next_rvalid  = REG_READ;
		uid_byte_sel = REG_ADDR[3:0];
		if (REG_READ) begin
			// identifier bytes decode as a range, the rest by exact address
			if (REG_ADDR >= UNIQUE_ID_BASE && REG_ADDR <= UNIQUE_ID_LAST) begin
				next_rdata = UID_VALUE[uid_byte_sel*8 +: 8];
			end else begin
				// reserved upper bits pad as zero
				case (REG_ADDR)
					LANGUAGE_CODE_LOW_ADDR:  next_rdata = language_code_low;
					LANGUAGE_CODE_HIGH_ADDR: next_rdata = language_code_high;
					SERIAL_LENGTH_ADDR:      next_rdata = {2'h0, serial_string_length};
					MAKER_LENGTH_ADDR:       next_rdata = {1'h0, maker_string_length};
					default:                 next_rdata = 8'h00;
				endcase
			end
		end
	end

	// read answer registers; data falls back to zero when no read was taken
	always_ff @(posedge CLK_SYS) begin
		if (CE) begin
			if (RESET) begin
				REG_RDATA  <= 8'h00;
				REG_RVALID <= 1'h0;
			end else begin
				REG_RDATA  <= next_rdata;
				REG_RVALID <= next_rvalid;
			end
		end
	end

	// string descriptor length lookup for the descriptor logic
	logic [7:0] next_desc_length;
	logic       next_desc_present;
	logic       next_desc_ack;

	always_comb begin
		next_desc_ack     = DESC_REQ;
		next_desc_length  = 8'h00;
		next_desc_present = 1'h0;
		if (DESC_REQ) begin
			case (DESC_INDEX)
				// one language code only, two payload bytes
				STRING_INDEX_LANGUAGE: begin
					next_desc_length  = LANGUAGE_CODE_BYTES;
					next_desc_present = 1'h1;
				end
				STRING_INDEX_SERIAL: begin
					next_desc_length  = {2'h0, serial_string_length};
					next_desc_present = (serial_string_length != 6'h00);
				end
				STRING_INDEX_MAKER: begin
					next_desc_length  = {1'h0, maker_string_length};
					next_desc_present = (maker_string_length != 7'h00);
				end
				// index 2 is served elsewhere and answers absent here
				default: begin
					next_desc_length  = 8'h00;
					next_desc_present = 1'h0;
				end
			endcase
		end
	end

	// descriptor answer registers, one cycle after the request
	always_ff @(posedge CLK_SYS) begin
		if (CE) begin
			if (RESET) begin
				DESC_ACK     <= 1'h0;
				DESC_LENGTH  <= 8'h00;
				DESC_PRESENT <= 1'h0;
			end else begin
				DESC_ACK     <= next_desc_ack;
				DESC_LENGTH  <= next_desc_length;
				DESC_PRESENT <= next_desc_present;
			end
		end
	end

	// field values straight from the stored registers, identifier from the build-time constant
	assign UNIQUE_ID            = UID_VALUE;
	assign LANGUAGE_CODE        = {language_code_high, language_code_low};
	assign SERIAL_STRING_LENGTH = serial_string_length;
	assign MAKER_STRING_LENGTH  = maker_string_length;

endmodule

// file: descriptor_string_config_regs_tb.sv
// self-checking bench for the descriptor string register bank
`timescale 1ns/1ns
module descriptor_string_config_regs_tb;
	localparam logic [127:0] SEED = 128'h5A5A_5A5A_5A5A_5A5A_5A5A_5A5A_5A5A_5A5A; // arbitrary
	logic clk = 0, reset = 1, ce = 1, so = 0, se = 0, req = 0, rvalid, ack, pres, v, write, read;
	logic [1:0] idx = 0;
	logic [7:0] addr, wdata, rdata, dlen, d;
	logic [127:0] uid_out, uid;
	logic [15:0] lang;
	logic [5:0] slen;
	logic [6:0] mlen;
	int fails = 0, check_count = 0, e, m[4];
	always #20 clk = ~clk;
	cfg_host host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .addr(addr), .wdata(wdata),
		.write(write), .read(read));
	descriptor_string_config_regs #(.UID_SEED(SEED)) dut (.CLK_SYS(clk), .RESET(reset),
		.CE(ce), .STRING_OVERRIDE_ENABLE(so), .SERIAL_OVERRIDE_ENABLE(se), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WRITE(write), .REG_READ(read), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .DESC_REQ(req), .DESC_INDEX(idx), .DESC_ACK(ack),
		.DESC_LENGTH(dlen), .DESC_PRESENT(pres), .UNIQUE_ID(uid_out), .LANGUAGE_CODE(lang),
		.SERIAL_STRING_LENGTH(slen), .MAKER_STRING_LENGTH(mlen));
	// compare and close
	task automatic chk(input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// reset and model defaults
	task automatic do_reset();
		@(posedge clk) reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		m = '{9, 4, 24, 0};
	endtask
	// write through the host and update the model
	task automatic wr(int a, int dv);
		host.wr(a[7:0], dv[7:0]);
		if (a == 34 && se)
			m[2] = (dv % 64 > 32) ? 32 : dv % 64;
		else if (a == 35 && so)
			m[3] = (dv % 128 > 64) ? 64 : dv % 128;
		else if ((a == 32 || a == 33) && so)
			m[a-32] = dv;
	endtask
	function automatic int exp_rd(int a);
		if (a >= 16 && a < 32)
			return uid[8*(a-16) +: 8];
		return (a >= 32 && a < 36) ? m[a-32] : 0;
	endfunction
	// every byte around the bank, all descriptor indices, field outputs
	task automatic check_all();
		for (int a = 14; a < 40; a++) begin
			host.rd(a[7:0], d, v);
			chk({7'h0, v, d}, 16'h0100 | 16'(exp_rd(a)));
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) {req, idx} <= {1'b1, 2'(i)};
			@(posedge clk) req <= 1'b0;
			e = (i == 0) ? 2 : (i == 2) ? 0 : m[(i + 3) / 2];
			#1 chk({6'h0, ack, pres, dlen}, 16'(512 + 256 * (e != 0) + e));
		end
		chk(lang, 16'(m[1] * 256 + m[0]));
		chk({2'h0, mlen, 1'b0, slen}, 16'(m[3] * 128 + m[2]));
		chk(16'(uid_out !== uid), 16'h0000);
	endtask
	initial begin
		uid = SEED;
		uid[55:52] = 4'h4;
		uid[71:70] = 2'h2;
		void'($urandom(32'h2ace));
		do_reset();
		check_all();
		$display("defaults test done");
		for (int i = 0; i < 40; i++) begin
			@(posedge clk) {so, se} <= (i < 2) ? 2'h3 : 2'($urandom);
			if (i < 2)
				wr(34 + i, i * 64);
			else
				wr(14 + $urandom % 26, $urandom % 256);
			check_all();
		end
		$display("random write test done");
		// frozen bank takes neither writes nor reads
		@(posedge clk) {ce, so, se} <= 3'h3;
		host.wr(8'h20, 8'(~m[0]));
		host.wr(8'h22, 8'((m[2] == 0) ? 1 : 0));
		host.rd(8'h20, d, v);
		chk({7'h0, v, d}, 16'h0000);
		chk(lang, 16'(m[1] * 256 + m[0]));
		chk({10'h0, slen}, 16'(m[2]));
		@(posedge clk) ce <= 1'b1;
		check_all();
		$display("freeze test done");
		do_reset();
		check_all();
		$display("second reset test done");
		wrap_up();
	end
	// hang guard
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		wrap_up();
	end
endmodule

// file: dsc_chk.sv
// port assertions for the descriptor string register bank
`timescale 1ns/1ns
module dsc_chk
	import desc_string_pkg::*;
(
	// clock, reset and enable
	input wire logic         CLK_SYS,
	input wire logic         RESET,
	input wire logic         CE,
	// override enables and request strobes
	input wire logic         STRING_OVERRIDE_ENABLE,
	input wire logic         SERIAL_OVERRIDE_ENABLE,
	input wire logic         REG_WRITE,
	input wire logic         REG_READ,
	input wire logic [7:0]   REG_ADDR,
	input wire logic [7:0]   REG_WDATA,
	input wire logic         DESC_REQ,
	input wire logic [1:0]   DESC_INDEX,
	// answers and field values
	input wire logic [7:0]   REG_RDATA,
	input wire logic         REG_RVALID,
	input wire logic         DESC_ACK,
	input wire logic [7:0]   DESC_LENGTH,
	input wire logic         DESC_PRESENT,
	input wire logic [127:0] UNIQUE_ID,
	input wire logic [15:0]  LANGUAGE_CODE,
	input wire logic [5:0]   SERIAL_STRING_LENGTH,
	input wire logic [6:0]   MAKER_STRING_LENGTH
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// identifier fixed and formatted
	uid_fixed_a: assert property ($stable(UNIQUE_ID))
		else $error("identifier moved");
	uid_format_a: assert property (UNIQUE_ID[55:52] == 4'h4 && UNIQUE_ID[71:70] == 2'h2)
		else $error("identifier format bad");
	// locked fields hold, lengths stay in range
	lang_lock_a: assert property (CE && !STRING_OVERRIDE_ENABLE |=> $stable(LANGUAGE_CODE))
		else $error("language moved while locked");
	ser_lock_a: assert property (
		CE && !SERIAL_OVERRIDE_ENABLE |=> $stable(SERIAL_STRING_LENGTH))
		else $error("serial length moved while locked");
	mkr_lock_a: assert property (
		CE && !STRING_OVERRIDE_ENABLE |=> $stable(MAKER_STRING_LENGTH))
		else $error("maker length moved while locked");
	ce_hold_a: assert property (
		!CE |=> $stable(LANGUAGE_CODE) && $stable(SERIAL_STRING_LENGTH) && $stable(REG_RVALID))
		else $error("state moved while frozen");
	len_max_a: assert property (SERIAL_STRING_LENGTH <= 6'h20 && MAKER_STRING_LENGTH <= 7'h40)
		else $error("length above limit");
	// writes, reads and descriptor answers
	lang_write_a: assert property (
		CE && REG_WRITE && STRING_OVERRIDE_ENABLE && REG_ADDR == 8'h20
		|=> LANGUAGE_CODE[7:0] == $past(REG_WDATA))
		else $error("language low write lost");
	ser_read_a: assert property (
		CE && REG_READ && REG_ADDR == 8'h22
		|=> REG_RVALID && REG_RDATA == {2'h0, $past(SERIAL_STRING_LENGTH)})
		else $error("serial length read wrong");
	desc_serial_a: assert property (
		CE && DESC_REQ && DESC_INDEX == 2'h1 |=> DESC_ACK
		&& DESC_LENGTH == {2'h0, $past(SERIAL_STRING_LENGTH)}
		&& DESC_PRESENT == ($past(SERIAL_STRING_LENGTH) != 6'h00))
		else $error("serial descriptor wrong");
endmodule
bind descriptor_string_config_regs dsc_chk chk_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE),
	.REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .DESC_REQ(DESC_REQ), .REG_ADDR(REG_ADDR),
	.STRING_OVERRIDE_ENABLE(STRING_OVERRIDE_ENABLE), .REG_WDATA(REG_WDATA),
	.SERIAL_OVERRIDE_ENABLE(SERIAL_OVERRIDE_ENABLE), .REG_RDATA(REG_RDATA),
	.DESC_LENGTH(DESC_LENGTH), .REG_RVALID(REG_RVALID), .DESC_ACK(DESC_ACK),
	.DESC_PRESENT(DESC_PRESENT), .DESC_INDEX(DESC_INDEX), .UNIQUE_ID(UNIQUE_ID),
	.LANGUAGE_CODE(LANGUAGE_CODE), .SERIAL_STRING_LENGTH(SERIAL_STRING_LENGTH),
	.MAKER_STRING_LENGTH(MAKER_STRING_LENGTH));
